// File: logic/cbsm_exec.sv
// cbsm_exec: executes branch-on-interrupt-flag, io bit, shift, flag, move and
// indirect load instructions against a register file and status flags
// assumes: one instruction presented with instr_valid while instr_ready is high;
// data memory and io space answer a read while its strobe stands
//
// How it works
// - branch on interrupts on: pc+offset+1, 1/2 cycles
// - branch on interrupts off: pc+offset+1, 1/2 cycles
// - io bit set, two cycles, flags kept
// - io bit clear, two cycles, flags kept
// - shift left, zero in, flags updated
// - shift right, zero in bit seven
// - rotate left through carry, flags updated
// - rotate right through carry, flags updated
// - arithmetic shift right keeps sign bit
// - copy register bit into transfer flag
// - write transfer flag into register bit
// - set or clear overflow flag only
// - set or clear half carry only
// - set or clear signed flag only
// - interrupt enable sets global flag
// - interrupt disable clears global flag
// - register copy, one cycle, no flags
// - load then increment pointer, two cycles
// - decrement pointer then load, two cycles
`timescale 1ns/1ps
module cbsm_exec #(
	parameter int NUM_REGS = cbsm_pkg::CBSM_NUM_REGS
) (
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      resetn,
	// instruction port
	input  wire logic                      instr_valid,
	input  wire cbsm_pkg::cbsm_instr_type  instr,
	output logic                           instr_ready,
	// data memory and io space
	output cbsm_pkg::cbsm_mem_req_type     mem_req,
	input  wire logic [7:0]                mem_rdata,
	output cbsm_pkg::cbsm_mem_req_type     io_req,
	input  wire logic [7:0]                io_rdata,
	// architectural state
	output logic [15:0]                    pc,
	output logic [7:0]                     status_flags,
	output logic [NUM_REGS*8-1:0]          reg_file
);
	import cbsm_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		cbsm_state_type   state;
		cbsm_instr_type   held;
		logic [15:0]      pc;
		logic [7:0]       flags;
		logic [NUM_REGS*8-1:0] regs;
		cbsm_mem_req_type mem;
		cbsm_mem_req_type io;
	} cbsm_core_type;

	cbsm_core_type core_reg;
	cbsm_core_type core_next;

	// ==========================================================
	// helpers
	function automatic logic [7:0] rd_reg(input logic [NUM_REGS*8-1:0] r,
	                                       input logic [4:0] i);
		rd_reg = r[i*8 +: 8];
	endfunction

	// pointer register pair selected by src field: src with bit 0 cleared names the low register
	function automatic logic [15:0] rd_ptr(input logic [NUM_REGS*8-1:0] r,
	                                        input logic [4:0] i);
		logic [4:0] lo;
		lo = {i[4:1], 1'b0};
		rd_ptr = {r[(lo+5'd1)*8 +: 8], r[lo*8 +: 8]};
	endfunction

	// ==========================================================
	// shift unit
	logic [7:0] sh_result;
	logic       sh_carry;
	logic       sh_zero;
	logic       sh_neg;
	logic       sh_ovf;
	logic       sh_sign;

	cbsm_shift_unit cbsm_shift_unit_i (
		.op          (instr.op),
		.value       (rd_reg(core_reg.regs, instr.dst)),
		.carry_in    (core_reg.flags[CBSM_FLAG_C]),
		.result      (sh_result),
		.carry_out   (sh_carry),
		.zero        (sh_zero),
		.negative    (sh_neg),
		.overflow    (sh_ovf),
		.signed_flag (sh_sign)
	);

	// ==========================================================
	// next state
	always_comb begin
		logic        take;
		logic [15:0] ptr;
		logic [7:0]  val;
		logic [4:0]  plo;
		take = 1'b0;
		ptr  = 16'h0000;
		val  = 8'h00;
		plo  = 5'd0;
		core_next = core_reg;
		core_next.mem.rd_en = 1'b0;
		core_next.mem.wr_en = 1'b0;
		core_next.io.rd_en  = 1'b0;
		core_next.io.wr_en  = 1'b0;
		unique case (core_reg.state)
			CBSM_ST_IDLE: begin
				if (instr_valid) begin
					core_next.held = instr;
					core_next.pc   = core_reg.pc + 16'h0001;
					unique case (instr.op)
						CBSM_OP_BRANCH_IF_INTS_ON,
						CBSM_OP_BRANCH_IF_INTS_OFF: begin
							take = (instr.op == CBSM_OP_BRANCH_IF_INTS_ON) ?
							       core_reg.flags[CBSM_FLAG_I] :
							       !core_reg.flags[CBSM_FLAG_I];
							if (take) begin
								core_next.pc = core_reg.pc + {{8{instr.offset[7]}},
								               instr.offset} + 16'h0001;
								core_next.state = CBSM_ST_SECOND;
							end
						end
						CBSM_OP_IO_BIT_SET,
						CBSM_OP_IO_BIT_CLEAR: begin
							// read cycle; modify and write in the second cycle
							core_next.io.rd_en = 1'b1;
							core_next.io.addr  = {11'h000, instr.io_addr};
							core_next.state    = CBSM_ST_SECOND;
						end
						CBSM_OP_SHIFT_LEFT, CBSM_OP_SHIFT_RIGHT,
						CBSM_OP_ROTATE_LEFT_CARRY, CBSM_OP_ROTATE_RIGHT_CARRY,
						CBSM_OP_ARITH_SHIFT_RIGHT: begin
							core_next.regs[instr.dst*8 +: 8] = sh_result;
							core_next.flags[CBSM_FLAG_C] = sh_carry;
							core_next.flags[CBSM_FLAG_Z] = sh_zero;
							core_next.flags[CBSM_FLAG_N] = sh_neg;
							core_next.flags[CBSM_FLAG_V] = sh_ovf;
							core_next.flags[CBSM_FLAG_S] = sh_sign;
						end
						CBSM_OP_NIBBLE_SWAP:
							core_next.regs[instr.dst*8 +: 8] = sh_result;
						CBSM_OP_STATUS_BIT_SET:
							core_next.flags[instr.bit_sel] = 1'b1;
						CBSM_OP_STATUS_BIT_CLEAR:
							core_next.flags[instr.bit_sel] = 1'b0;
						CBSM_OP_REG_BIT_TO_TFLAG: begin
							val = rd_reg(core_reg.regs, instr.src);
							core_next.flags[CBSM_FLAG_T] = val[instr.bit_sel];
						end
						CBSM_OP_TFLAG_TO_REG_BIT:
							core_next.regs[instr.dst*8 + instr.bit_sel] =
								core_reg.flags[CBSM_FLAG_T];
						CBSM_OP_OVERFLOW_SET:     core_next.flags[CBSM_FLAG_V] = 1'b1;
						CBSM_OP_OVERFLOW_CLEAR:   core_next.flags[CBSM_FLAG_V] = 1'b0;
						CBSM_OP_HALF_CARRY_SET:   core_next.flags[CBSM_FLAG_H] = 1'b1;
						CBSM_OP_HALF_CARRY_CLEAR: core_next.flags[CBSM_FLAG_H] = 1'b0;
						CBSM_OP_SIGNED_SET:       core_next.flags[CBSM_FLAG_S] = 1'b1;
						CBSM_OP_SIGNED_CLEAR:     core_next.flags[CBSM_FLAG_S] = 1'b0;
						CBSM_OP_INTS_ENABLE:      core_next.flags[CBSM_FLAG_I] = 1'b1;
						CBSM_OP_INTS_DISABLE:     core_next.flags[CBSM_FLAG_I] = 1'b0;
						CBSM_OP_REGISTER_COPY:
							core_next.regs[instr.dst*8 +: 8] =
								rd_reg(core_reg.regs, instr.src);
						CBSM_OP_REGISTER_PAIR_COPY: begin
							plo = {instr.src[4:1], 1'b0};
							ptr = {rd_reg(core_reg.regs, plo + 5'd1), rd_reg(core_reg.regs, plo)};
							plo = {instr.dst[4:1], 1'b0};
							core_next.regs[plo*8 +: 8]         = ptr[7:0];
							core_next.regs[(plo+5'd1)*8 +: 8]  = ptr[15:8];
						end
						CBSM_OP_LOAD_POST_INC: begin
							ptr = rd_ptr(core_reg.regs, instr.src);
							core_next.mem.rd_en = 1'b1;
							core_next.mem.addr  = ptr;
							plo = {instr.src[4:1], 1'b0};
							{core_next.regs[(plo+5'd1)*8 +: 8], core_next.regs[plo*8 +: 8]} =
								ptr + 16'h0001;
							core_next.state = CBSM_ST_SECOND;
						end
						CBSM_OP_LOAD_PRE_DEC: begin
							ptr = rd_ptr(core_reg.regs, instr.src) - 16'h0001;
							core_next.mem.rd_en = 1'b1;
							core_next.mem.addr  = ptr;
							plo = {instr.src[4:1], 1'b0};
							{core_next.regs[(plo+5'd1)*8 +: 8], core_next.regs[plo*8 +: 8]} =
								ptr;
							core_next.state = CBSM_ST_SECOND;
						end
						default: begin
							core_next.pc = core_reg.pc + 16'h0001;
						end
					endcase
				end
			end
			CBSM_ST_SECOND: begin
				core_next.state = CBSM_ST_IDLE;
				unique case (core_reg.held.op)
					CBSM_OP_IO_BIT_SET, CBSM_OP_IO_BIT_CLEAR: begin
						val = io_rdata;
						val[core_reg.held.bit_sel] =
							(core_reg.held.op == CBSM_OP_IO_BIT_SET);
						core_next.io.wr_en = 1'b1;
						core_next.io.wdata = val;
					end
					CBSM_OP_LOAD_POST_INC, CBSM_OP_LOAD_PRE_DEC:
						core_next.regs[core_reg.held.dst*8 +: 8] = mem_rdata;
					default: begin
						core_next.state = CBSM_ST_IDLE;
					end
				endcase
			end
			default: core_next.state = CBSM_ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			core_reg.state <= CBSM_ST_IDLE;
			core_reg.held  <= '0;
			core_reg.pc    <= CBSM_PC_RESET;
			core_reg.flags <= CBSM_FLAGS_RESET;
			core_reg.regs  <= {NUM_REGS{CBSM_REG_RESET}};
			core_reg.mem   <= '0;
			core_reg.io    <= '0;
		end else begin
			core_reg <= core_next;
		end
	end

	// ==========================================================
	// outputs
	assign instr_ready  = (core_reg.state == CBSM_ST_IDLE);
	assign mem_req      = core_reg.mem;
	assign io_req       = core_reg.io;
	assign pc           = core_reg.pc;
	assign status_flags = core_reg.flags;
	assign reg_file     = core_reg.regs;

endmodule

// File: logic/cbsm_pkg.sv
// cbsm_pkg: constants, opcodes and carriers for the shift / bit / move executor
// assumes: 8-bit registers, 16-bit program counter and data addresses
package cbsm_pkg;

	// ==========================================================
	// status flag positions
	localparam int CBSM_FLAG_C = 0;
	localparam int CBSM_FLAG_Z = 1;
	localparam int CBSM_FLAG_N = 2;
	localparam int CBSM_FLAG_V = 3;
	localparam int CBSM_FLAG_S = 4;
	localparam int CBSM_FLAG_H = 5;
	localparam int CBSM_FLAG_T = 6;
	localparam int CBSM_FLAG_I = 7;

	// ==========================================================
	// reset values and cycle counts
	localparam logic [7:0]  CBSM_FLAGS_RESET = 8'h00;
	localparam logic [15:0] CBSM_PC_RESET    = 16'h0000;
	localparam logic [7:0]  CBSM_REG_RESET   = 8'h00;
	localparam int          CBSM_NUM_REGS    = 32;
	localparam int          CBSM_CYC_LOAD    = 2;
	localparam int          CBSM_CYC_IO_BIT  = 2;
	localparam int          CBSM_CYC_BR_TAKEN = 2;

	// ==========================================================
	// operations
	typedef enum logic [4:0] {
		CBSM_OP_NONE                = 5'h00,
		CBSM_OP_BRANCH_IF_INTS_ON   = 5'h01,
		CBSM_OP_BRANCH_IF_INTS_OFF  = 5'h02,
		CBSM_OP_IO_BIT_SET          = 5'h03,
		CBSM_OP_IO_BIT_CLEAR        = 5'h04,
		CBSM_OP_SHIFT_LEFT          = 5'h05,
		CBSM_OP_SHIFT_RIGHT         = 5'h06,
		CBSM_OP_ROTATE_LEFT_CARRY   = 5'h07,
		CBSM_OP_ROTATE_RIGHT_CARRY  = 5'h08,
		CBSM_OP_ARITH_SHIFT_RIGHT   = 5'h09,
		CBSM_OP_NIBBLE_SWAP         = 5'h0a,
		CBSM_OP_STATUS_BIT_SET      = 5'h0b,
		CBSM_OP_STATUS_BIT_CLEAR    = 5'h0c,
		CBSM_OP_REG_BIT_TO_TFLAG    = 5'h0d,
		CBSM_OP_TFLAG_TO_REG_BIT    = 5'h0e,
		CBSM_OP_OVERFLOW_SET        = 5'h0f,
		CBSM_OP_OVERFLOW_CLEAR      = 5'h10,
		CBSM_OP_HALF_CARRY_SET      = 5'h11,
		CBSM_OP_HALF_CARRY_CLEAR    = 5'h12,
		CBSM_OP_SIGNED_SET          = 5'h13,
		CBSM_OP_SIGNED_CLEAR        = 5'h14,
		CBSM_OP_INTS_ENABLE         = 5'h15,
		CBSM_OP_INTS_DISABLE        = 5'h16,
		CBSM_OP_REGISTER_COPY       = 5'h17,
		CBSM_OP_REGISTER_PAIR_COPY  = 5'h18,
		CBSM_OP_LOAD_POST_INC       = 5'h19,
		CBSM_OP_LOAD_PRE_DEC        = 5'h1a
	} cbsm_op_type;

	// ==========================================================
	// carriers
	typedef struct packed {
		cbsm_op_type op;
		logic [4:0]  dst;
		logic [4:0]  src;
		logic [2:0]  bit_sel;
		logic [7:0]  offset;
		logic [4:0]  io_addr;
	} cbsm_instr_type;

	typedef struct packed {
		logic        rd_en;
		logic        wr_en;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} cbsm_mem_req_type;

	typedef enum logic [1:0] {
		CBSM_ST_IDLE   = 2'b00,
		CBSM_ST_SECOND = 2'b01
	} cbsm_state_type;

endpackage

// File: logic/cbsm_shift_unit.sv
// cbsm_shift_unit: combinational shift, rotate and swap with flag results
// assumes: caller merges the flags it returns only for shift-class operations
`timescale 1ns/1ps
module cbsm_shift_unit (
	// operation and operand
	input  wire cbsm_pkg::cbsm_op_type op,
	input  wire logic [7:0]            value,
	input  wire logic                  carry_in,
	// result
	output logic [7:0]                 result,
	output logic                       carry_out,
	output logic                       zero,
	output logic                       negative,
	output logic                       overflow,
	output logic                       signed_flag
);
	import cbsm_pkg::*;

	always_comb begin
		result    = value;
		carry_out = carry_in;
		unique case (op)
			CBSM_OP_SHIFT_LEFT: begin
				result    = {value[6:0], 1'b0};
				carry_out = value[7];
			end
			CBSM_OP_SHIFT_RIGHT: begin
				result    = {1'b0, value[7:1]};
				carry_out = value[0];
			end
			CBSM_OP_ROTATE_LEFT_CARRY: begin
				result    = {value[6:0], carry_in};
				carry_out = value[7];
			end
			CBSM_OP_ROTATE_RIGHT_CARRY: begin
				result    = {carry_in, value[7:1]};
				carry_out = value[0];
			end
			CBSM_OP_ARITH_SHIFT_RIGHT: begin
				result    = {value[7], value[7:1]};
				carry_out = value[0];
			end
			CBSM_OP_NIBBLE_SWAP: begin
				result = {value[3:0], value[7:4]};
			end
			default: begin
				result    = value;
				carry_out = carry_in;
			end
		endcase
		zero        = (result == 8'h00);
		negative    = result[7];
		// overflow is negative xor carry for every shift and rotate
		overflow    = result[7] ^ carry_out;
		signed_flag = negative ^ overflow;
	end

endmodule

// File: tb/cbsm_exec_sva.sv
// cbsm_exec_sva: timing and result checks at the executor ports
// assumes: bound to cbsm_exec; io reads are answered while the strobe stands
`timescale 1ns/1ps
module cbsm_exec_sva #(
	parameter int NUM_REGS = 32
) (
	// clock and reset
	input wire logic	ref_clk,
	input wire logic	resetn,
	// instruction and requests
	input wire logic	instr_valid,
	input wire cbsm_pkg::cbsm_instr_type	instr,
	input wire logic	instr_ready,
	input wire cbsm_pkg::cbsm_mem_req_type	mem_req,
	input wire cbsm_pkg::cbsm_mem_req_type	io_req,
	input wire logic [7:0]	io_rdata,
	// state
	input wire logic [15:0]	pc,
	input wire logic [7:0]	status_flags,
	input wire logic [NUM_REGS*8-1:0]	reg_file
);
	import cbsm_pkg::*;
	wire	take = instr_valid && instr_ready;
	wire [15:0]	ptr = reg_file[{instr.src[4:1], 4'b0000} +: 16];
	wire [15:0]	k_ext = {{8{instr.offset[7]}}, instr.offset};
	wire [7:0]	mask = 8'h01 << instr.bit_sel;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// ====================
	// steps
	sequence s_two;
		!instr_ready ##1 instr_ready;
	endsequence
	// read strobe alone, then the write strobe alone in the next cycle
	sequence s_io_rmw;
		io_req.rd_en && !io_req.wr_en ##1 io_req.wr_en && !io_req.rd_en;
	endsequence
	// ====================
	// assertions
	post_inc_addr_a: assert property (take && instr.op == CBSM_OP_LOAD_POST_INC |=>
		mem_req.rd_en && mem_req.addr == $past(ptr) ##0 s_two) else $error("post-inc address");
	pre_dec_addr_a: assert property (take && instr.op == CBSM_OP_LOAD_PRE_DEC |=>
		mem_req.rd_en && mem_req.addr == $past(ptr) - 16'h0001 ##0 s_two) else $error("pre-dec address");
	io_set_a: assert property (take && instr.op == CBSM_OP_IO_BIT_SET |=> s_io_rmw ##0
		io_req.addr[4:0] == $past(instr.io_addr, 2)
		&& io_req.wdata == ($past(io_rdata) | $past(mask, 2))) else $error("io set");
	io_clear_a: assert property (take && instr.op == CBSM_OP_IO_BIT_CLEAR |=> s_io_rmw ##0
		io_req.addr[4:0] == $past(instr.io_addr, 2)
		&& io_req.wdata == ($past(io_rdata) & ~$past(mask, 2))) else $error("io clear");
	branch_on_a: assert property (take && instr.op == CBSM_OP_BRANCH_IF_INTS_ON && status_flags[7] |=>
		pc == $past(pc) + $past(k_ext) + 16'h0001 ##0 s_two) else $error("taken branch");
	branch_off_a: assert property (take && instr.op == CBSM_OP_BRANCH_IF_INTS_OFF && status_flags[7] |=>
		pc == $past(pc) + 16'h0001 && instr_ready) else $error("branch not taken");
	copy_flags_a: assert property (take && instr.op == CBSM_OP_REGISTER_COPY |=>
		$stable(status_flags)) else $error("copy changed flags");
	ints_on_a: assert property (take && instr.op == CBSM_OP_INTS_ENABLE |=>
		status_flags == ($past(status_flags) | 8'h80)) else $error("interrupt enable");
endmodule

// File: tb/cbsm_exec_tb.sv
// cbsm_exec_tb: self-checking bench for the shift, bit and move executor
// assumes: cbsm_mem_model answers reads; a reference state is kept here
`timescale 1ns/1ps
module cbsm_exec_tb;
	import cbsm_pkg::*;
	logic	ref_clk = 1'b0;
	logic	resetn = 1'b0;
	logic	instr_valid = 1'b0;
	cbsm_instr_type	instr = '0;
	logic	instr_ready;
	cbsm_mem_req_type	mem_req, io_req;
	logic [7:0]	mem_rdata, io_rdata, status_flags, f, r [32], io_e [32];
	logic [15:0]	pc, p;
	logic [255:0]	reg_file;
	int	errors = 0, n_checks = 0;
	always #25 ref_clk = ~ref_clk;
	cbsm_exec cbsm_exec_i (.ref_clk(ref_clk), .resetn(resetn), .instr_valid(instr_valid),
		.instr(instr), .instr_ready(instr_ready), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.io_req(io_req), .io_rdata(io_rdata), .pc(pc), .status_flags(status_flags),
		.reg_file(reg_file));
	cbsm_mem_model cbsm_mem_model_i (.ref_clk(ref_clk), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .io_req(io_req), .io_rdata(io_rdata));
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// ====================
	// one instruction: reference update, drive, then judge
	task automatic go(cbsm_op_type op, logic [4:0] d, logic [4:0] s = 0, logic [2:0] b = 0,
			logic [7:0] k = 0, logic [4:0] a = 0);
		logic [7:0]	v, res;
		logic [15:0]	pt;
		logic	c;
		int	n, cyc;
		int	fi [4] = '{3, 5, 4, 7};
		v = r[d];
		res = v;
		c = f[0];
		pt = {r[s | 5'd1], r[s & 5'h1e]};
		p = p + 16'h0001;
		cyc = 1;
		if (op == CBSM_OP_IO_BIT_SET || op == CBSM_OP_IO_BIT_CLEAR) cyc = CBSM_CYC_IO_BIT;
		if (op >= CBSM_OP_LOAD_POST_INC) cyc = CBSM_CYC_LOAD;
		case (op)
			CBSM_OP_BRANCH_IF_INTS_ON, CBSM_OP_BRANCH_IF_INTS_OFF: begin
				if (f[7] == (op == CBSM_OP_BRANCH_IF_INTS_ON)) begin
					p = p + {{8{k[7]}}, k};
					cyc = CBSM_CYC_BR_TAKEN;
				end
			end
			CBSM_OP_IO_BIT_SET: io_e[a][b] = 1'b1;
			CBSM_OP_IO_BIT_CLEAR: io_e[a][b] = 1'b0;
			CBSM_OP_SHIFT_LEFT: {c, res} = {v, 1'b0};
			CBSM_OP_SHIFT_RIGHT: {res, c} = {1'b0, v};
			CBSM_OP_ROTATE_LEFT_CARRY: {c, res} = {v, f[0]};
			CBSM_OP_ROTATE_RIGHT_CARRY: {res, c} = {f[0], v};
			CBSM_OP_ARITH_SHIFT_RIGHT: {res, c} = {v[7], v};
			CBSM_OP_NIBBLE_SWAP: r[d] = {v[3:0], v[7:4]};
			CBSM_OP_STATUS_BIT_SET: f[b] = 1'b1;
			CBSM_OP_STATUS_BIT_CLEAR: f[b] = 1'b0;
			CBSM_OP_REG_BIT_TO_TFLAG: f[6] = r[s][b];
			CBSM_OP_TFLAG_TO_REG_BIT: r[d][b] = f[6];
			CBSM_OP_REGISTER_COPY: r[d] = r[s];
			CBSM_OP_REGISTER_PAIR_COPY: {r[d | 5'd1], r[d & 5'h1e]} = pt;
			CBSM_OP_LOAD_POST_INC: begin
				r[d] = pt[7:0] * 8'h1d + 8'h07;
				{r[s | 5'd1], r[s & 5'h1e]} = pt + 16'h0001;
			end
			CBSM_OP_LOAD_PRE_DEC: begin
				pt = pt - 16'h0001;
				{r[s | 5'd1], r[s & 5'h1e]} = pt;
				r[d] = pt[7:0] * 8'h1d + 8'h07;
			end
			default: begin
				if (op >= CBSM_OP_OVERFLOW_SET && op <= CBSM_OP_INTS_DISABLE) begin
					f[fi[(op - 15) / 2]] = op[0];
				end
			end
		endcase
		if (op >= CBSM_OP_SHIFT_LEFT && op <= CBSM_OP_ARITH_SHIFT_RIGHT) begin
			r[d] = res;
			f[4:0] = {c, res[7] ^ c, res[7], res == 8'h00, c};
		end
		for (n = 0; n < 8 && instr_ready !== 1'b1; n++) @(posedge ref_clk) #1;
		if (instr_ready !== 1'b1) begin
			errors++;
			end_sim();
		end
		instr = '{op, d, s, b, k, a};
		instr_valid = 1'b1;
		@(posedge ref_clk) #1;
		instr_valid = 1'b0;
		chk(instr_ready, cyc == 1);
		if (cyc == 2) begin
			@(posedge ref_clk) #1;
			chk(instr_ready, 1'b1);
		end
		repeat (2) @(posedge ref_clk);
		#1;
		chk(pc, p);
		chk(status_flags, f);
		for (int i = 0; i < 32; i++) chk(reg_file[i*8 +: 8], r[i]);
		chk(cbsm_mem_model_i.io_mem[a], io_e[a]);
	endtask
	// ====================
	// scenarios
	task automatic t_loads;
		for (int i = 0; i < 8; i++) go(CBSM_OP_LOAD_POST_INC, 5'(i), 5'd26);
		go(CBSM_OP_LOAD_PRE_DEC, 5'd8, 5'd26);
	endtask
	task automatic t_shifts;
		for (int i = 0; i < 12; i++) go(cbsm_op_type'(5'(5 + i % 6)), 5'(i % 8));
		go(CBSM_OP_SHIFT_LEFT, 5'd9);
	endtask
	task automatic t_flags;
		for (int i = 15; i < 23; i++) go(cbsm_op_type'(5'(i)), 5'd0);
		go(CBSM_OP_NONE, 5'd0);
		for (int i = 0; i < 16; i++) go(i < 8 ? CBSM_OP_STATUS_BIT_SET : CBSM_OP_STATUS_BIT_CLEAR, 5'd0, 5'd0, 3'(i));
	endtask
	task automatic t_moves;
		go(CBSM_OP_REG_BIT_TO_TFLAG, 5'd0, 5'd3, 3'd1);
		go(CBSM_OP_TFLAG_TO_REG_BIT, 5'd10, 5'd0, 3'd5);
		go(CBSM_OP_REG_BIT_TO_TFLAG, 5'd0, 5'd5, 3'd7);
		go(CBSM_OP_TFLAG_TO_REG_BIT, 5'd7, 5'd0, 3'd7);
		go(CBSM_OP_REGISTER_COPY, 5'd11, 5'd7);
		go(CBSM_OP_REGISTER_PAIR_COPY, 5'd13, 5'd5);
	endtask
	task automatic t_branch;
		go(CBSM_OP_BRANCH_IF_INTS_ON, 5'd0, 5'd0, 3'd0, 8'h05);
		go(CBSM_OP_BRANCH_IF_INTS_OFF, 5'd0, 5'd0, 3'd0, 8'hf0);
		go(CBSM_OP_INTS_ENABLE, 5'd0);
		go(CBSM_OP_BRANCH_IF_INTS_ON, 5'd0, 5'd0, 3'd0, 8'h7f);
		go(CBSM_OP_BRANCH_IF_INTS_OFF, 5'd0, 5'd0, 3'd0, 8'h80);
	endtask
	task automatic t_io;
		go(CBSM_OP_IO_BIT_SET, 5'd0, 5'd0, 3'd0, 8'h00, 5'd4);
		go(CBSM_OP_IO_BIT_CLEAR, 5'd0, 5'd0, 3'd0, 8'h00, 5'd5);
		go(CBSM_OP_IO_BIT_SET, 5'd0, 5'd0, 3'd7, 8'h00, 5'd5);
		go(CBSM_OP_IO_BIT_CLEAR, 5'd0, 5'd0, 3'd2, 8'h00, 5'd31);
	endtask
	// mid-run reset: state returns to its reset values, the first op runs at once
	task automatic t_reset;
		resetn = 1'b0;
		#1;
		chk(instr_ready, 1'b1);
		chk(pc, CBSM_PC_RESET);
		chk(status_flags, CBSM_FLAGS_RESET);
		chk({mem_req.rd_en, io_req.rd_en, io_req.wr_en}, 3'h0);
		for (int i = 0; i < 32; i++) chk(reg_file[i*8 +: 8], CBSM_REG_RESET);
		repeat (2) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		f = CBSM_FLAGS_RESET;
		p = CBSM_PC_RESET;
		for (int i = 0; i < 32; i++) r[i] = CBSM_REG_RESET;
		go(CBSM_OP_INTS_ENABLE, 5'd0);
		go(CBSM_OP_LOAD_POST_INC, 5'd2, 5'd30);
	endtask
	initial begin
		f = 8'h00;
		p = 16'h0000;
		for (int i = 0; i < 32; i++) begin
			r[i] = 8'h00;
			io_e[i] = 8'(i * 8'h33);
		end
		repeat (6) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		t_loads();
		t_shifts();
		t_flags();
		t_moves();
		t_branch();
		t_io();
		t_reset();
		end_sim();
	end
endmodule
bind cbsm_exec cbsm_exec_sva #(.NUM_REGS(NUM_REGS)) cbsm_exec_sva_i (.ref_clk(ref_clk),
	.resetn(resetn), .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
	.mem_req(mem_req), .io_req(io_req), .io_rdata(io_rdata), .pc(pc),
	.status_flags(status_flags), .reg_file(reg_file));

// File: tb/cbsm_mem_model.sv
// cbsm_mem_model: data memory and io register space facing the executor
// assumes: a read is answered while its strobe stands; data memory holds a fixed pattern
`timescale 1ns/1ps
module cbsm_mem_model (
	// clock
	input wire logic	ref_clk,
	// data memory
	input wire cbsm_pkg::cbsm_mem_req_type	mem_req,
	output logic [7:0]	mem_rdata,
	// io space
	input wire cbsm_pkg::cbsm_mem_req_type	io_req,
	output logic [7:0]	io_rdata
);
	import cbsm_pkg::*;
	logic [7:0]	io_mem [32];
	logic [7:0]	mem_word;
	logic [7:0]	io_word;
	initial begin
		for (int i = 0; i < 32; i++) begin
			io_mem[i] = 8'(i * 8'h33);
		end
	end
	// read data stands while the strobe does; a released bus shows the inverse
	always_comb begin
		mem_word = mem_req.addr[7:0] * 8'h1d + 8'h07;
		io_word = io_mem[io_req.addr[4:0]];
		mem_rdata = mem_req.rd_en ? mem_word : ~mem_word;
		io_rdata = io_req.rd_en ? io_word : ~io_word;
	end
	always @(posedge ref_clk) begin
		if (io_req.wr_en) begin
			io_mem[io_req.addr[4:0]] <= io_req.wdata;
		end
	end
endmodule
